// [hdl/vtsc_pkg.sv]
// Constants, register map and carrier types for the video timing and sync control block.
// Assumes a single 40 MHz APB clock domain; pins are synchronised inside the block.
`default_nettype none
package vtsc_pkg;
  localparam int unsigned ADDR_W = 10;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_PLL = 8'h00;
  localparam logic [7:0] IDX_INMODE = 8'h01;
  localparam logic [7:0] IDX_SDED_RATE = 8'h0d;
  localparam logic [7:0] IDX_EDHD_STD = 8'h30;
  localparam logic [7:0] IDX_HD_RATE = 8'h31;
  localparam logic [7:0] IDX_EDHD_TRST = 8'h34;
  localparam logic [7:0] IDX_SD_MODE2 = 8'h82;
  localparam logic [7:0] IDX_SD_MODE4 = 8'h84;
  localparam logic [7:0] IDX_SD_SLAVE = 8'h8a;
  localparam logic [7:0] IDX_FIELD_CNT = 8'hbb;
  // Field positions.
  localparam int unsigned PLL_OFF_BIT = 1;
  localparam int unsigned RATE_BIT = 3;
  localparam int unsigned HD_RATE_BIT = 1;
  localparam int unsigned TRST_BIT = 0;
  localparam int unsigned TRICK_BIT = 5;
  localparam int unsigned LOCK_LSB = 1;
  localparam int unsigned INMODE_LSB = 4;
  localparam int unsigned STD_LSB = 3;
  // Reset values and encodings.
  localparam logic [7:0] PLL_RST = 8'h02;
  localparam logic [2:0] IN_SD = 3'h0;
  localparam logic [2:0] IN_SDR = 3'h1;
  localparam logic [2:0] IN_DDR = 3'h2;
  localparam logic [2:0] IN_ED54 = 3'h7;
  localparam logic [4:0] STD_NONSTD = 5'h01;
  localparam logic [4:0] STD_HD_MIN = 5'h08;
  localparam logic [1:0] LOCK_OFF = 2'h0;
  localparam logic [1:0] LOCK_PHASE = 2'h1;
  localparam logic [1:0] LOCK_TIMING = 2'h2;
  localparam logic [1:0] LOCK_FREQ = 2'h3;
  localparam logic [2:0] SLAVE_MODE0 = 3'h0;
  // Oversampling factors.
  localparam logic [4:0] OS_1X = 5'h01;
  localparam logic [4:0] OS_2X = 5'h02;
  localparam logic [4:0] OS_4X = 5'h04;
  localparam logic [4:0] OS_8X = 5'h08;
  localparam logic [4:0] OS_16X = 5'h10;
  // Lock stream framing and first field number.
  localparam int unsigned LOCK_BITS = 67;
  localparam int unsigned FSC_BITS = 22;
  localparam logic [6:0] LOCK_LAST = 7'h42;
  localparam logic [4:0] FIELD_FIRST = 5'h01;
  typedef enum logic [1:0] {VTSC_BLANK = 2'h0, VTSC_SYNC = 2'h1, VTSC_TRI = 2'h3} vtsc_level_t;
  typedef struct packed {
    logic [10:0] h;
    logic [10:0] v;
    logic [4:0] field;
  } vtsc_sd_t;
  typedef struct packed {
    logic [11:0] h;
    logic [10:0] v;
  } vtsc_edhd_t;
endpackage : vtsc_pkg
`default_nettype wire

// [hdl/vtsc_top.sv]
// Video timing and sync control: oversampling select, ED/HD nonstandard sync levels,
// timing resets, lock pin decode, lock stream receiver and tape trick-play sync.
// Assumes APB master on pclk; sync and lock pins are asynchronous to pclk.
// How it works
// - Oversampling PLL is off after reset; writing zero to its control bit enables it.
// - SD input: 2x with PLL off, else 8x or 16x by rate bit.
// - ED input, 54 MHz included: 1x with PLL off, else 4x or 8x.
// - HD input: 1x with PLL off, else 2x or 4x by HD rate bit.
// - Standard field pattern 00001 selects ED/HD nonstandard timing mode.
// - Sync pin levels in nonstandard mode choose blank, sync or tri-level output.
// - Nonstandard mode ignores embedded codes and times from the sync pins only.
// - Nonstandard mode forces the PLL off and disables oversampling.
// - ED/HD timing reset bit holds ED/HD counters at zero; SD counters unaffected.
// - Lock pin function: 10 timing reset, 01 phase reset, 11 frequency lock.
// - Timing reset: pin high holds SD counters; release restarts at field one, phase reset.
// - Phase reset mode: rising edge zeroes phase at next field start, field kept.
// - Field count register shows the active field number.
// - Frequency lock mode takes the lock stream and updates frequency per line.
// - Lock frame is 67 bits, frequency in bits 0 to 21, two cycles per bit.
// - Trick-play sync updates line and field counters from incoming vertical sync.
// - Trick-play sync has no effect in slave mode 0.
// - Input mode field: 000 SD, 001 SDR, 010 DDR, 111 ED at 54 MHz.
//
// Our own choices: the register offsets and the APB register port.
`default_nettype none
module vtsc_top #(
  parameter int unsigned SD_LINE = 1716,
  parameter int unsigned SD_LINES = 525,
  parameter int unsigned SD_FIELDS = 4,
  parameter int unsigned EDHD_LINE = 1716,
  parameter int unsigned EDHD_LINES = 525
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vtsc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hsync_n,
  input wire logic vsync_n,
  input wire logic subcarrier_lock_pin,
  input wire logic embedded_sync,
  output logic pll_enable,
  output logic [4:0] oversample,
  output logic nonstd_mode,
  output vtsc_pkg::vtsc_level_t sync_level,
  output vtsc_pkg::vtsc_sd_t sd_timing,
  output vtsc_pkg::vtsc_edhd_t edhd_timing,
  output logic phase_reset,
  output logic [vtsc_pkg::FSC_BITS-1:0] fsc_value,
  output logic fsc_update
);
  import vtsc_pkg::*;

  function automatic logic [4:0] os_pick(input logic pll_on, input logic sel,
                                         input logic [4:0] f_off, input logic [4:0] f1,
                                         input logic [4:0] f0);
    os_pick = !pll_on ? f_off : (sel ? f1 : f0);
  endfunction : os_pick

  logic [7:0] pll_q, inmode_q, rate_q, std_q, hdrate_q, trst_q, mode2_q, mode4_q, slave_q;
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q;
  vtsc_sd_t sd_q;
  logic [7:0] idx;
  logic mapped;
  assign idx = paddr[ADDR_W-1:2];
  always_comb begin
    unique case (idx)
      IDX_PLL, IDX_INMODE, IDX_SDED_RATE, IDX_EDHD_STD, IDX_HD_RATE, IDX_EDHD_TRST,
      IDX_SD_MODE2, IDX_SD_MODE4, IDX_SD_SLAVE, IDX_FIELD_CNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // One wait state: the access phase ends at the second edge with a registered answer.
  wire acc_end = psel && penable && pready_q;
  wire wr = acc_end && pwrite && mapped;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !mapped;
      if (psel && penable && !pready_q && !pwrite) begin
        unique case (idx)
          IDX_PLL: prdata_q <= {24'h0, pll_q};
          IDX_INMODE: prdata_q <= {24'h0, inmode_q};
          IDX_SDED_RATE: prdata_q <= {24'h0, rate_q};
          IDX_EDHD_STD: prdata_q <= {24'h0, std_q};
          IDX_HD_RATE: prdata_q <= {24'h0, hdrate_q};
          IDX_EDHD_TRST: prdata_q <= {24'h0, trst_q};
          IDX_SD_MODE2: prdata_q <= {24'h0, mode2_q};
          IDX_SD_MODE4: prdata_q <= {24'h0, mode4_q};
          IDX_SD_SLAVE: prdata_q <= {24'h0, slave_q};
          IDX_FIELD_CNT: prdata_q <= {27'h0, sd_q.field};
          default: prdata_q <= 32'h0;
        endcase
      end
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_q <= PLL_RST;
      inmode_q <= 8'h00;
      rate_q <= 8'h00;
      std_q <= 8'h00;
      hdrate_q <= 8'h00;
      trst_q <= 8'h00;
      mode2_q <= 8'h00;
      mode4_q <= 8'h00;
      slave_q <= 8'h00;
    end else if (wr) begin
      unique case (idx)
        IDX_PLL: pll_q <= pwdata[7:0];
        IDX_INMODE: inmode_q <= pwdata[7:0];
        IDX_SDED_RATE: rate_q <= pwdata[7:0];
        IDX_EDHD_STD: std_q <= pwdata[7:0];
        IDX_HD_RATE: hdrate_q <= pwdata[7:0];
        IDX_EDHD_TRST: trst_q <= pwdata[7:0];
        IDX_SD_MODE2: mode2_q <= pwdata[7:0];
        IDX_SD_MODE4: mode4_q <= pwdata[7:0];
        IDX_SD_SLAVE: slave_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  wire [2:0] in_mode = inmode_q[INMODE_LSB+:3];
  wire [4:0] std = std_q[STD_LSB+:5];
  wire [1:0] lock_mode = mode4_q[LOCK_LSB+:2];
  wire nonstd = (in_mode != IN_SD) && (std == STD_NONSTD);
  // Hardware keeps the PLL off in nonstandard mode even if software forgets.
  wire pll_on = !pll_q[PLL_OFF_BIT] && !nonstd;
  wire trick_on = mode2_q[TRICK_BIT] && (slave_q[2:0] != SLAVE_MODE0);

  // Three-stage synchronisers; a level counts once stages two and three agree.
  logic [2:0] hs_s, vs_s, lk_s;
  logic hs_q, vs_q, lk_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_s <= 3'h7;
      vs_s <= 3'h7;
      lk_s <= 3'h0;
      hs_q <= 1'b1;
      vs_q <= 1'b1;
      lk_q <= 1'b0;
    end else begin
      hs_s <= {hs_s[1:0], hsync_n};
      vs_s <= {vs_s[1:0], vsync_n};
      lk_s <= {lk_s[1:0], subcarrier_lock_pin};
      if (hs_s[1] == hs_s[2]) hs_q <= hs_s[2];
      if (vs_s[1] == vs_s[2]) vs_q <= vs_s[2];
      if (lk_s[1] == lk_s[2]) lk_q <= lk_s[2];
    end
  end
  wire hs_c = (hs_s[1] == hs_s[2]) ? hs_s[2] : hs_q;
  wire vs_c = (vs_s[1] == vs_s[2]) ? vs_s[2] : vs_q;
  wire lk_c = (lk_s[1] == lk_s[2]) ? lk_s[2] : lk_q;
  wire hs_fall = hs_q && !hs_c;
  wire vs_fall = vs_q && !vs_c;
  wire lk_rise = !lk_q && lk_c;
  wire lk_fall = lk_q && !lk_c;

  logic pll_en_q, nonstd_q;
  logic [4:0] os_q;
  vtsc_level_t lvl_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_en_q <= 1'b0;
      nonstd_q <= 1'b0;
      os_q <= OS_1X;
      lvl_q <= VTSC_BLANK;
    end else begin
      pll_en_q <= pll_on;
      nonstd_q <= nonstd;
      if (in_mode == IN_SD)
        os_q <= os_pick(pll_on, rate_q[RATE_BIT], OS_2X, OS_8X, OS_16X);
      else if (in_mode == IN_ED54 || std < STD_HD_MIN)
        os_q <= os_pick(pll_on, rate_q[RATE_BIT], OS_1X, OS_4X, OS_8X);
      else
        os_q <= os_pick(pll_on, hdrate_q[HD_RATE_BIT], OS_1X, OS_2X, OS_4X);
      if (!nonstd) lvl_q <= VTSC_BLANK;
      else if (hs_c) lvl_q <= VTSC_BLANK;
      else lvl_q <= vs_c ? VTSC_TRI : VTSC_SYNC;
    end
  end
  assign pll_enable = pll_en_q;
  assign nonstd_mode = nonstd_q;
  assign oversample = os_q;
  assign sync_level = lvl_q;

  // ED/HD counters: pins only in nonstandard mode, embedded codes otherwise.
  vtsc_edhd_t ed_q;
  wire ed_line = nonstd ? hs_fall : embedded_sync;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ed_q <= '0;
    else if (trst_q[TRST_BIT]) ed_q <= '0;
    else if (ed_line || ed_q.h == 12'(EDHD_LINE - 1)) begin
      ed_q.h <= 12'h000;
      if (nonstd && vs_fall) ed_q.v <= 11'h000;
      else ed_q.v <= (ed_q.v == 11'(EDHD_LINES - 1)) ? 11'h000 : ed_q.v + 11'h001;
    end else ed_q.h <= ed_q.h + 12'h001;
  end
  assign edhd_timing = ed_q;

  // SD counters with timing reset, phase reset and trick-play alignment.
  logic trst_hold_q, phres_pend_q, ph_q;
  wire sd_eol = sd_q.h == 11'(SD_LINE - 1);
  wire sd_eof = sd_eol && sd_q.v == 11'(SD_LINES - 1);
  wire trick_v = trick_on && vs_fall;
  wire next_field = sd_eof || trick_v;
  wire [4:0] field_inc = (sd_q.field == 5'(SD_FIELDS)) ? FIELD_FIRST : sd_q.field + 5'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) trst_hold_q <= 1'b0;
    else if (lock_mode != LOCK_TIMING) trst_hold_q <= 1'b0;
    else if (lk_rise) trst_hold_q <= 1'b1;
    else if (lk_fall) trst_hold_q <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sd_q <= '{h: 11'h000, v: 11'h000, field: FIELD_FIRST};
    else if (trst_hold_q || (lock_mode == LOCK_TIMING && lk_rise)) begin
      sd_q <= '{h: 11'h000, v: 11'h000, field: FIELD_FIRST};
    end else if (next_field) begin
      sd_q.h <= 11'h000;
      sd_q.v <= 11'h000;
      sd_q.field <= field_inc;
    end else if (sd_eol) begin
      sd_q.h <= 11'h000;
      sd_q.v <= sd_q.v + 11'h001;
    end else sd_q.h <= sd_q.h + 11'h001;
  end
  assign sd_timing = sd_q;

  // A new request in the cycle the pending one is served keeps it pending.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) phres_pend_q <= 1'b0;
    else if (lock_mode == LOCK_PHASE && lk_rise) phres_pend_q <= 1'b1;
    else if (next_field || lock_mode != LOCK_PHASE) phres_pend_q <= 1'b0;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_q <= 1'b0;
    else ph_q <= (trst_hold_q && lk_fall) || (phres_pend_q && next_field);
  end
  assign phase_reset = ph_q;

  // Lock stream: a frame opens on a high bit while idle; each bit lasts two cycles.
  logic busy_q, half_q, have_q, upd_q;
  logic [6:0] bit_q;
  logic [FSC_BITS-1:0] sh_q, fsc_q;
  wire freq_mode = lock_mode == LOCK_FREQ;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      half_q <= 1'b0;
      bit_q <= 7'h00;
      sh_q <= '0;
      have_q <= 1'b0;
    end else if (!freq_mode) begin
      busy_q <= 1'b0;
      have_q <= 1'b0;
    end else begin
      // Clearing comes first so a frame that ends at a line end is not lost.
      if (have_q && sd_eol) have_q <= 1'b0;
      if (!busy_q) begin
        busy_q <= lk_c;
        half_q <= 1'b1;
        bit_q <= 7'h00;
      end else begin
        half_q <= !half_q;
        if (half_q) begin
          if (bit_q < 7'(FSC_BITS)) sh_q <= {lk_c, sh_q[FSC_BITS-1:1]};
          if (bit_q == LOCK_LAST) begin
            busy_q <= 1'b0;
            have_q <= 1'b1;
          end
          bit_q <= bit_q + 7'h01;
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fsc_q <= '0;
      upd_q <= 1'b0;
    end else begin
      upd_q <= freq_mode && have_q && sd_eol;
      if (freq_mode && have_q && sd_eol) fsc_q <= sh_q;
    end
  end
  assign fsc_value = fsc_q;
  assign fsc_update = upd_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  pll_nonstd_a: assert property (nonstd |=> !pll_enable) else $error("PLL on in nonstd");
  pll_bit_a: assert property (pll_q[PLL_OFF_BIT] |=> !pll_enable) else $error("PLL not off");
  sd_rate_a: assert property (in_mode == IN_SD && pll_on && !rate_q[RATE_BIT] |=>
    oversample == OS_16X) else $error("SD 16x wrong");
  hd_rate_a: assert property (in_mode == IN_SDR && std >= STD_HD_MIN && !pll_on |=>
    oversample == OS_1X) else $error("HD 1x wrong");
  ed_rst_a: assert property (trst_q[TRST_BIT] |=> edhd_timing == '0)
    else $error("ED/HD counters not held");
  tri_lvl_a: assert property (nonstd && !hs_c && vs_c |=> sync_level == VTSC_TRI)
    else $error("tri-level missing");
  sd_hold_a: assert property (trst_hold_q |=> sd_timing.h == 11'h000 &&
    sd_timing.field == FIELD_FIRST) else $error("SD not held");
  phase_field_a: assert property (phres_pend_q && next_field && lock_mode == LOCK_PHASE |=>
    phase_reset && $stable(sd_timing.field) == 1'b0) else $error("phase reset late");
  off_mode_a: assert property (lock_mode == LOCK_OFF |=> !phase_reset && !fsc_update)
    else $error("lock pin not ignored");
  fsc_bit_a: assert property (busy_q && half_q |=> !half_q) else $error("bit timing");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("APB answer late");
  trst_c: cover property (trst_hold_q ##1 phase_reset);
  freq_c: cover property (fsc_update);
  trick_c: cover property (trick_v);
endmodule : vtsc_top
`default_nettype wire

// [verification/vtsc_src.sv]
// Behavioural video source: sync pins, lock pin and embedded code strobe.
// Assumes the bench calls its tasks just after a rising edge of pclk.
`default_nettype none
module vtsc_src (
  input wire logic pclk,
  output logic hsync_n,
  output logic vsync_n,
  output logic subcarrier_lock_pin,
  output logic embedded_sync
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    hsync_n = 1'h1;
    vsync_n = 1'h1;
    subcarrier_lock_pin = 1'h0;
    embedded_sync = 1'h0;
  end
  // The level is held long enough for the pin synchronisers to settle.
  // Pixels are not modelled, so blanking-level data stays the source's own concern.
  task automatic pins(input logic h, input logic v);
    @(posedge pclk);
    hsync_n <= h;
    vsync_n <= v;
    repeat (8) @(posedge pclk);
  endtask : pins
  task automatic pulse(input int n);
    @(posedge pclk);
    subcarrier_lock_pin <= 1'h1;
    repeat (n) @(posedge pclk);
    subcarrier_lock_pin <= 1'h0;
  endtask : pulse
  task automatic embed();
    @(posedge pclk);
    embedded_sync <= 1'h1;
    @(posedge pclk);
    embedded_sync <= 1'h0;
  endtask : embed
  // Bits above the frequency field toggle so a stuck receiver shows up.
  task automatic frame(input logic [21:0] f);
    for (int i = 0; i < 67; i++) begin
      @(posedge pclk);
      subcarrier_lock_pin <= (i < 22) ? f[i] : i[0];
      @(posedge pclk);
    end
    @(posedge pclk);
    subcarrier_lock_pin <= 1'h0;
  endtask : frame
endmodule : vtsc_src
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the video timing and sync control block.
// Assumes the source model vtsc_src and an APB master on a 40 MHz clock.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vtsc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic hsync_n, vsync_n, subcarrier_lock_pin, embedded_sync;
  logic pll_enable, nonstd_mode, phase_reset, fsc_update;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] oversample;
  logic [FSC_BITS-1:0] fsc_value;
  vtsc_level_t sync_level;
  vtsc_sd_t sd_timing;
  vtsc_edhd_t edhd_timing;
  int fails = 0;
  int comparisons = 0;
  vtsc_top #(.SD_LINE(16), .SD_LINES(4)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .hsync_n, .vsync_n, .subcarrier_lock_pin, .embedded_sync, .pll_enable, .oversample,
    .nonstd_mode, .sync_level, .sd_timing, .edhd_timing, .phase_reset, .fsc_value, .fsc_update);
  vtsc_src src (.pclk, .hsync_n, .vsync_n, .subcarrier_lock_pin, .embedded_sync);
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : acc
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    acc(1'h1, idx, d);
  endtask : wr
  task automatic cnt(input int n, output int c);
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      if (phase_reset === 1'h1) c++;
    end
  endtask : cnt
  function automatic logic [4:0] os_exp(logic [2:0] m, logic hd, logic off, logic r, logic hr);
    if (off) return (m == IN_SD) ? OS_2X : OS_1X;
    if (m == IN_SD) return r ? OS_8X : OS_16X;
    if (hd) return hr ? OS_2X : OS_4X;
    return r ? OS_4X : OS_8X;
  endfunction : os_exp
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    report_and_stop();
  end
  initial begin
    logic [2:0] m;
    logic hd;
    int c;
    vtsc_sd_t s;
    vtsc_level_t lv[5];
    // Pin levels per step, bit i for step i.
    logic [4:0] hb;
    logic [4:0] vb;
    lv = '{VTSC_SYNC, VTSC_TRI, VTSC_BLANK, VTSC_SYNC, VTSC_BLANK};
    hb = 5'h14;
    vb = 5'h06;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk("pll_en", pll_enable, 0);
    chk("os_rst", oversample, OS_1X);
    @(posedge pclk);
    chk("os_sd", oversample, OS_2X);
    acc(1'h0, IDX_PLL, 8'h00);
    chk("pll_reg", rd, PLL_RST);
    acc(1'h0, 8'h55, 8'h00);
    chk("unmap_err", err, 1);
    chk("unmap_rd", rd, 0);
    for (int k = 0; k < 64; k++) begin
      m = (k[1:0] == 2'h3) ? IN_ED54 : {1'h0, k[1:0]};
      hd = k[2] && (m == IN_SDR || m == IN_DDR);
      wr(IDX_INMODE, {1'h0, m, 4'h0});
      wr(IDX_EDHD_STD, {hd ? STD_HD_MIN : 5'h02, 3'h0});
      wr(IDX_PLL, {6'h0, k[3], 1'h0});
      wr(IDX_SDED_RATE, {4'h0, k[4], 3'h0});
      wr(IDX_HD_RATE, {6'h0, k[5], 1'h0});
      repeat (2) @(posedge pclk);
      chk("pll_on", pll_enable, !k[3]);
      chk("os", oversample, os_exp(m, hd, k[3], k[4], k[5]));
    end
    wr(IDX_INMODE, {1'h0, IN_SDR, 4'h0});
    wr(IDX_EDHD_STD, 8'h10);
    wr(IDX_EDHD_TRST, 8'h01);
    s = sd_timing;
    repeat (20) @(posedge pclk);
    chk("edhd_hold", edhd_timing, 0);
    chk("sd_runs", sd_timing != s, 1);
    wr(IDX_EDHD_TRST, 8'h00);
    repeat (4) @(posedge pclk);
    chk("edhd_run", edhd_timing != 0, 1);
    src.embed();
    @(posedge pclk);
    chk("embed_line", edhd_timing.h, 0);
    wr(IDX_EDHD_STD, {STD_NONSTD, 3'h0});
    wr(IDX_PLL, 8'h00);
    repeat (2) @(posedge pclk);
    chk("nonstd", nonstd_mode, 1);
    chk("pll_forced", pll_enable, 0);
    chk("os_nonstd", oversample, OS_1X);
    src.embed();
    @(posedge pclk);
    chk("embed_ignored", edhd_timing.h != 12'h000, 1);
    for (int i = 0; i < 5; i++) begin
      src.pins(hb[i], vb[i]);
      chk("level", sync_level, lv[i]);
    end
    src.pins(1'h1, 1'h1);
    wr(IDX_EDHD_STD, 8'h10);
    wr(IDX_SD_MODE4, {5'h0, LOCK_TIMING, 1'h0});
    src.pulse(10);
    chk("trst_hold", sd_timing.h, 0);
    cnt(8, c);
    chk("trst_phase", c, 1);
    chk("trst_field", sd_timing.field, FIELD_FIRST);
    wr(IDX_FIELD_CNT, 8'hff);
    acc(1'h0, IDX_FIELD_CNT, 8'h00);
    chk("field_reg", rd, FIELD_FIRST);
    wr(IDX_SD_MODE4, {5'h0, LOCK_OFF, 1'h0});
    src.pulse(10);
    cnt(80, c);
    chk("off_phase", c, 0);
    wr(IDX_SD_MODE4, {5'h0, LOCK_PHASE, 1'h0});
    c = 0;
    while (sd_timing.field != 5'h03 && c < 300) begin
      @(posedge pclk);
      c++;
    end
    src.pulse(3);
    cnt(80, c);
    chk("phres_phase", c, 1);
    wr(IDX_SD_MODE4, {5'h0, LOCK_FREQ, 1'h0});
    src.frame(22'h2a5a5b);
    c = 0;
    while (fsc_update !== 1'h1 && c < 100) begin
      @(posedge pclk);
      c++;
    end
    chk("fsc_upd", c < 100, 1);
    chk("fsc", fsc_value, 22'h2a5a5b);
    wr(IDX_SD_MODE4, 8'h00);
    wr(IDX_SD_SLAVE, 8'h01);
    wr(IDX_SD_MODE2, 8'h20);
    // Start mid-line so a natural field end cannot fall inside the check.
    for (int i = 0; i < 2; i++) begin
      c = 0;
      while (!(sd_timing.h == 11'h8 && sd_timing.v == 11'h0) && c < 200) begin
        @(posedge pclk);
        c++;
      end
      s = sd_timing;
      src.pins(1'h1, 1'h0);
      chk("trick", sd_timing.field, i ? s.field : (s.field % 4) + 1);
      src.pins(1'h1, 1'h1);
      wr(IDX_SD_SLAVE, 8'h00);
    end
    // A second reset mid-run must bring back the power-on settings.
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    chk("pll_en_rst", pll_enable, 0);
    chk("os_rst2", oversample, OS_1X);
    presetn <= 1'h1;
    @(posedge pclk);
    acc(1'h0, IDX_PLL, 8'h00);
    chk("pll_reg_rst", rd, PLL_RST);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
